// ### rtiv_pkg.sv
// package for the clock interrupt and entry-validity register block
// assumes an axi4-lite slave with 32-bit data, one aligned word per register
package rtiv_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS     = 8'h00; // clock_status_flags, read only
  localparam logic [7:0] OFF_STAT_CLR   = 8'h04; // write one to clear a status flag
  localparam logic [7:0] OFF_IRQ_ON     = 8'h08; // interrupt_enable_set
  localparam logic [7:0] OFF_IRQ_OFF    = 8'h0C; // interrupt_enable_clear
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h10; // interrupt_mask_view
  localparam logic [7:0] OFF_VALIDITY   = 8'h14; // entry_validity_flags
  localparam logic [7:0] OFF_CTRL       = 8'h18; // event selection fields
  localparam logic [7:0] OFF_TIME_DAY   = 8'h1C; // time_of_day_register
  localparam logic [7:0] OFF_CALENDAR   = 8'h20; // calendar_register
  localparam logic [7:0] OFF_TIME_ALARM = 8'h24; // time_alarm_register
  localparam logic [7:0] OFF_CAL_ALARM  = 8'h28; // calendar_alarm_register
  localparam logic [7:0] OFF_MODE       = 8'h2C; // 12/24 hour mode

  // source bit positions in status, enable, disable and mask registers
  localparam int BIT_UPD   = 0;
  localparam int BIT_ALARM = 1;
  localparam int BIT_SEC   = 2;
  localparam int BIT_TIMEV = 3;
  localparam int BIT_CALEV = 4;
  localparam int NUM_SRC   = 5;

  // validity bit positions
  localparam int BIT_BAD_TIME  = 0;
  localparam int BIT_BAD_CAL   = 1;
  localparam int BIT_BAD_TALR  = 2;
  localparam int BIT_BAD_CALR  = 3;
  localparam int NUM_VALID     = 4;

  // control field positions
  localparam int CTRL_TSEL_LSB = 8;
  localparam int CTRL_CSEL_LSB = 16;

  // reset values
  localparam logic [4:0]  MASK_RST   = 5'h00;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] TIME_RST   = 32'h0000_0000;
  localparam logic [31:0] CAL_RST    = 32'h0001_0120; // century 20, year 01, month 01; day and date left zero, so the checker rejects it
  localparam logic [31:0] ALARM_RST  = 32'h0000_0000;
  localparam logic [31:0] CALR_RST   = 32'h0101_0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // time event choices
  typedef enum logic [1:0] {TEV_MINUTE, TEV_HOUR, TEV_NOON, TEV_MIDNIGHT} rtiv_tev_t;
endpackage

// ### rtiv_check.sv
// range checker for programmed bcd time, calendar and alarm words
// assumes purely combinational use by the register block
module rtiv_check (
  input  wire logic [31:0] TIME_W,
  input  wire logic [31:0] CAL_W,
  input  wire logic [31:0] TALR_W,
  input  wire logic [31:0] CALR_W,
  input  wire logic        HOUR12,
  output logic      [3:0]  BAD
);
  // true when a bcd byte lies in lo..hi with legal digits
  function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  // hour depends on mode; am/pm must be zero in 24 hour mode
  function automatic logic hour_ok(input logic [5:0] h, input logic pm, input logic m12);
    hour_ok = m12 ? bcd_ok({2'h0, h}, 8'h01, 8'h12) : (bcd_ok({2'h0, h}, 8'h00, 8'h23) && !pm);
  endfunction

  always_comb begin
    // time of day: seconds, minutes, hours
    BAD[0] = !(bcd_ok({1'b0, TIME_W[6:0]}, 8'h00, 8'h59) &&
               bcd_ok({1'b0, TIME_W[14:8]}, 8'h00, 8'h59) &&
               hour_ok(TIME_W[21:16], TIME_W[22], HOUR12));
    // calendar: century, year, month, day, date
    BAD[1] = !(bcd_ok({1'b0, CAL_W[6:0]}, 8'h19, 8'h20) &&
               bcd_ok(CAL_W[15:8], 8'h00, 8'h99) &&
               bcd_ok({3'h0, CAL_W[20:16]}, 8'h01, 8'h12) &&
               bcd_ok({5'h00, CAL_W[23:21]}, 8'h01, 8'h07) &&
               bcd_ok({2'h0, CAL_W[29:24]}, 8'h01, 8'h31));
    // time alarm: only enabled fields are checked
    BAD[2] = (TALR_W[7] && !bcd_ok({1'b0, TALR_W[6:0]}, 8'h00, 8'h59)) ||
             (TALR_W[15] && !bcd_ok({1'b0, TALR_W[14:8]}, 8'h00, 8'h59)) ||
             (TALR_W[23] && !hour_ok(TALR_W[21:16], TALR_W[22], HOUR12));
    // calendar alarm: month and date
    BAD[3] = (CALR_W[23] && !bcd_ok({3'h0, CALR_W[20:16]}, 8'h01, 8'h12)) ||
             (CALR_W[31] && !bcd_ok({2'h0, CALR_W[29:24]}, 8'h01, 8'h31));
  end
endmodule // rtiv_check

// ### rtiv_regs.sv
// register block: status flags, interrupt mask, entry validity, axi4-lite slave
// assumes events arrive as one-cycle pulses synchronous to CLK
// Function
// - writing one clears status flag; zero ignored
// - sources at bits zero to four
// - enable write sets mask bits only
// - disable write clears mask bits only
// - mask register read-only, shows enabled sources
// - time enable follows selected time event
// - calendar enable follows selected calendar event
// - validity bit zero flags bad time
// - validity bit one flags bad calendar
// - validity bit two flags bad time alarm
// - validity bit three flags bad calendar alarm
// - status bits zero-four sticky until cleared
// - time event minute, hour, noon, midnight
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
module rtiv_regs (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        UPD_EVT,
  input  wire logic        ALARM_EVT,
  input  wire logic        SEC_EVT,
  input  wire logic [3:0]  TIME_EVTS,
  input  wire logic [2:0]  CAL_EVTS,
  output logic             IRQ
);
  // write channel holding state
  logic        aw_have_r, aw_have_nxt;  // address taken
  logic        w_have_r, w_have_nxt;    // data taken
  logic [7:0]  aw_addr_r, aw_addr_nxt;  // latched write address
  logic [31:0] w_data_r, w_data_nxt;    // latched write data
  logic [3:0]  w_strb_r, w_strb_nxt;    // latched byte strobes
  logic        bvalid_r, bvalid_nxt;    // write response pending
  logic [1:0]  bresp_r, bresp_nxt;      // write response code
  // read channel state
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  // block state
  logic [4:0]  status_r, status_nxt;    // sticky event flags
  logic [4:0]  mask_r, mask_nxt;        // interrupt enables
  logic [3:0]  valid_r, valid_nxt;      // bad-entry flags
  logic [31:0] ctrl_r, ctrl_nxt;        // event selections
  logic [31:0] time_r, time_nxt;        // stored time of day
  logic [31:0] cal_r, cal_nxt;          // stored calendar
  logic [31:0] talr_r, talr_nxt;        // stored time alarm
  logic [31:0] calr_r, calr_nxt;        // stored calendar alarm
  logic        mode_r, mode_nxt;        // 12 hour mode
  logic        irq_r, irq_nxt;          // registered interrupt
  logic [3:0]  bad_w;                   // checker verdict on written values
  logic        aw_rdy_r, aw_rdy_nxt;    // address slot free, registered for the port
  logic        w_rdy_r, w_rdy_nxt;      // data slot free, registered for the port
  logic        ar_rdy_r, ar_rdy_nxt;    // read slot free, registered for the port
  logic        do_wr;                   // write commits this cycle
  logic        tev_hit, cev_hit;        // selected event pulses
  logic [4:0]  evt_w;                   // event vector
  logic [31:0] rd_mux;                  // read data mux
  logic        rd_ok;                   // address decodes
  // control field positions, kept local for the part-selects below
  localparam int CTRL_TSEL_LSB_I = rtiv_pkg::CTRL_TSEL_LSB;
  localparam int CTRL_CSEL_LSB_I = rtiv_pkg::CTRL_CSEL_LSB;

  // merge strobed bytes over an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // candidate word seen by the checker is the stored word after this write
  logic [31:0] time_c, cal_c, talr_c, calr_c;
  always_comb begin
    time_c = time_nxt;
    cal_c  = cal_nxt;
    talr_c = talr_nxt;
    calr_c = calr_nxt;
  end

  rtiv_check u_check (
    .TIME_W (time_c),
    .CAL_W  (cal_c),
    .TALR_W (talr_c),
    .CALR_W (calr_c),
    .HOUR12 (mode_nxt),
    .BAD    (bad_w)
  );

  // selected event decode
  always_comb begin
    tev_hit = TIME_EVTS[ctrl_r[CTRL_TSEL_LSB_I +: 2]];
    cev_hit = (ctrl_r[CTRL_CSEL_LSB_I +: 2] == 2'h0) ? CAL_EVTS[0] :
              (ctrl_r[CTRL_CSEL_LSB_I +: 2] == 2'h1) ? CAL_EVTS[1] : CAL_EVTS[2];
    evt_w = '0;
    evt_w[rtiv_pkg::BIT_UPD]   = UPD_EVT;
    evt_w[rtiv_pkg::BIT_ALARM] = ALARM_EVT;
    evt_w[rtiv_pkg::BIT_SEC]   = SEC_EVT;
    evt_w[rtiv_pkg::BIT_TIMEV] = tev_hit;
    evt_w[rtiv_pkg::BIT_CALEV] = cev_hit;
  end

  // write channel: take address and data in any order, answer once both held
  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (S_AXI_AWVALID && aw_rdy_r) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && w_rdy_r) begin
      w_have_nxt = 1'b1;
      w_data_nxt = S_AXI_WDATA;
      w_strb_nxt = S_AXI_WSTRB;
    end
    do_wr = aw_have_r && w_have_r && !bvalid_r;
    if (do_wr) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = rd_decode(aw_addr_r) ? rtiv_pkg::RESP_OKAY : rtiv_pkg::RESP_SLVERR;
    end else if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
    end
    // a slot reopens only once its response has been taken
    aw_rdy_nxt = !aw_have_nxt && !bvalid_nxt;
    w_rdy_nxt  = !w_have_nxt && !bvalid_nxt;
  end

  // any mapped offset, reads or writes alike
  function automatic logic rd_decode(input logic [7:0] a);
    rd_decode = (a[1:0] == 2'h0) && (a <= rtiv_pkg::OFF_MODE);
  endfunction

  // register contents and flags
  always_comb begin
    status_nxt = status_r;
    mask_nxt   = mask_r;
    ctrl_nxt   = ctrl_r;
    time_nxt   = time_r;
    cal_nxt    = cal_r;
    talr_nxt   = talr_r;
    calr_nxt   = calr_r;
    mode_nxt   = mode_r;
    if (do_wr) begin
      unique case (aw_addr_r)
        rtiv_pkg::OFF_STAT_CLR: if (w_strb_r[0]) status_nxt = status_r & ~w_data_r[4:0];
        rtiv_pkg::OFF_IRQ_ON:   if (w_strb_r[0]) mask_nxt = mask_r | w_data_r[4:0];
        rtiv_pkg::OFF_IRQ_OFF:  if (w_strb_r[0]) mask_nxt = mask_r & ~w_data_r[4:0];
        rtiv_pkg::OFF_CTRL:       ctrl_nxt = merge(ctrl_r, w_data_r, w_strb_r) & 32'h0003_0300;
        rtiv_pkg::OFF_TIME_DAY:   time_nxt = merge(time_r, w_data_r, w_strb_r);
        rtiv_pkg::OFF_CALENDAR:   cal_nxt  = merge(cal_r, w_data_r, w_strb_r);
        rtiv_pkg::OFF_TIME_ALARM: talr_nxt = merge(talr_r, w_data_r, w_strb_r);
        rtiv_pkg::OFF_CAL_ALARM:  calr_nxt = merge(calr_r, w_data_r, w_strb_r);
        rtiv_pkg::OFF_MODE:     if (w_strb_r[0]) mode_nxt = w_data_r[0];
        default: ; // read-only or unmapped: no storage change
      endcase
    end
    // set wins over a clear in the same cycle
    status_nxt = status_nxt | evt_w;
    irq_nxt = |(status_nxt & mask_nxt);
  end

  // validity flags kept apart: the checker reads the next stored words, so
  // judging them in the store process would route a path back into it
  always_comb begin
    valid_nxt = valid_r;
    if (do_wr) begin
      // each watched register re-judged when written
      if (aw_addr_r == rtiv_pkg::OFF_TIME_DAY)   valid_nxt[0] = bad_w[0];
      if (aw_addr_r == rtiv_pkg::OFF_CALENDAR)   valid_nxt[1] = bad_w[1];
      if (aw_addr_r == rtiv_pkg::OFF_TIME_ALARM) valid_nxt[2] = bad_w[2];
      if (aw_addr_r == rtiv_pkg::OFF_CAL_ALARM)  valid_nxt[3] = bad_w[3];
    end
  end

  // read mux
  always_comb begin
    rd_ok  = rd_decode(S_AXI_ARADDR);
    rd_mux = 32'h0000_0000;
    unique case (S_AXI_ARADDR)
      rtiv_pkg::OFF_STATUS:     rd_mux = {27'h0, status_r};
      rtiv_pkg::OFF_IRQ_MASK:   rd_mux = {27'h0, mask_r};
      rtiv_pkg::OFF_VALIDITY:   rd_mux = {28'h0, valid_r};
      rtiv_pkg::OFF_CTRL:       rd_mux = ctrl_r;
      rtiv_pkg::OFF_TIME_DAY:   rd_mux = time_r;
      rtiv_pkg::OFF_CALENDAR:   rd_mux = cal_r;
      rtiv_pkg::OFF_TIME_ALARM: rd_mux = talr_r;
      rtiv_pkg::OFF_CAL_ALARM:  rd_mux = calr_r;
      rtiv_pkg::OFF_MODE:       rd_mux = {31'h0, mode_r};
      default:                  rd_mux = 32'h0000_0000; // write-only reads zero
    endcase
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (ar_rdy_r && S_AXI_ARVALID) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_mux;
      rresp_nxt  = rd_ok ? rtiv_pkg::RESP_OKAY : rtiv_pkg::RESP_SLVERR;
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end
    ar_rdy_nxt = !rvalid_nxt; // one read under way at a time
  end

  // all state registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= rtiv_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= rtiv_pkg::RESP_OKAY;
      status_r  <= 5'h00;
      mask_r    <= rtiv_pkg::MASK_RST;
      valid_r   <= 4'h0;
      ctrl_r    <= rtiv_pkg::CTRL_RST;
      time_r    <= rtiv_pkg::TIME_RST;
      cal_r     <= rtiv_pkg::CAL_RST;
      talr_r    <= rtiv_pkg::ALARM_RST;
      calr_r    <= rtiv_pkg::CALR_RST;
      mode_r    <= 1'b0;
      irq_r     <= 1'b0;
      aw_rdy_r  <= 1'b0;
      w_rdy_r   <= 1'b0;
      ar_rdy_r  <= 1'b0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      status_r  <= status_nxt;
      mask_r    <= mask_nxt;
      valid_r   <= valid_nxt;
      ctrl_r    <= ctrl_nxt;
      time_r    <= time_nxt;
      cal_r     <= cal_nxt;
      talr_r    <= talr_nxt;
      calr_r    <= calr_nxt;
      mode_r    <= mode_nxt;
      irq_r     <= irq_nxt;
      aw_rdy_r  <= aw_rdy_nxt;
      w_rdy_r   <= w_rdy_nxt;
      ar_rdy_r  <= ar_rdy_nxt;
    end
  end

  // ready only while a slot is free; registered, so low in reset and
  // high from the first edge after release
  assign S_AXI_AWREADY = aw_rdy_r;
  assign S_AXI_WREADY  = w_rdy_r;
  assign S_AXI_ARREADY = ar_rdy_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP  = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA  = rdata_r;
  assign S_AXI_RRESP  = rresp_r;
  assign IRQ          = irq_r;

  // assertions
  clr_one_a: assert property (@(posedge CLK) disable iff (RST)
    do_wr && aw_addr_r == rtiv_pkg::OFF_STAT_CLR && w_strb_r[0] && w_data_r[0] && !UPD_EVT
    |=> !status_r[0]) else $error("status clear failed");
  sticky_flag_a: assert property (@(posedge CLK) disable iff (RST)
    status_r[2] && !(do_wr && aw_addr_r == rtiv_pkg::OFF_STAT_CLR) |=> status_r[2])
    else $error("status flag dropped");
  sec_set_a: assert property (@(posedge CLK) disable iff (RST)
    SEC_EVT |=> status_r[2]) else $error("second event lost");
  en_set_a: assert property (@(posedge CLK) disable iff (RST)
    do_wr && aw_addr_r == rtiv_pkg::OFF_IRQ_ON && w_strb_r[0]
    |=> (mask_r == ($past(mask_r) | $past(w_data_r[4:0])))) else $error("enable wrong");
  dis_clr_a: assert property (@(posedge CLK) disable iff (RST)
    do_wr && aw_addr_r == rtiv_pkg::OFF_IRQ_OFF && w_strb_r[0]
    |=> (mask_r == ($past(mask_r) & ~$past(w_data_r[4:0])))) else $error("disable wrong");
  mask_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !(do_wr && (aw_addr_r == rtiv_pkg::OFF_IRQ_ON || aw_addr_r == rtiv_pkg::OFF_IRQ_OFF))
    |=> $stable(mask_r)) else $error("mask changed");
  tev_sel_a: assert property (@(posedge CLK) disable iff (RST)
    TIME_EVTS[ctrl_r[9:8]] |=> status_r[3]) else $error("time event lost");
  irq_lvl_a: assert property (@(posedge CLK) disable iff (RST)
    |(status_r & mask_r) |-> IRQ) else $error("irq low with flag");
  bad_time_a: assert property (@(posedge CLK) disable iff (RST)
    do_wr && aw_addr_r == rtiv_pkg::OFF_TIME_DAY |=> valid_r[0] == $past(bad_w[0]))
    else $error("time validity wrong");
  bresp_a: assert property (@(posedge CLK) disable iff (RST)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("bvalid dropped");
  wr_c: cover property (@(posedge CLK) do_wr && aw_addr_r == rtiv_pkg::OFF_IRQ_ON);
  irq_c: cover property (@(posedge CLK) $rose(IRQ));
  bad_c: cover property (@(posedge CLK) $rose(valid_r[1]));
endmodule // rtiv_regs

// ### tb_top.sv
// self-checking bench for the clock interrupt and entry-validity register block
// assumes the block stands alone: the bench drives its bus and event pulses itself
`define CHK(nm, ex, got) begin \
  n_checks++; \
  if ((got) !== (ex)) begin \
    num_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        CLK, RST;                          // system clock and async reset
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;        // register byte addresses
  logic        S_AXI_AWVALID, S_AXI_AWREADY;      // write address channel
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;          // data words
  logic [3:0]  S_AXI_WSTRB;                       // byte strobes
  logic        S_AXI_WVALID, S_AXI_WREADY;        // write data channel
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;          // responses
  logic        S_AXI_BVALID, S_AXI_BREADY;        // write response channel
  logic        S_AXI_ARVALID, S_AXI_ARREADY;      // read address channel
  logic        S_AXI_RVALID, S_AXI_RREADY;        // read data channel
  logic        UPD_EVT, ALARM_EVT, SEC_EVT, IRQ;  // single events and interrupt
  logic [3:0]  TIME_EVTS;                         // minute, hour, noon, midnight
  logic [2:0]  CAL_EVTS;                          // week, month, year
  int          num_errors, n_checks, cycles;      // bookkeeping
  logic [1:0]  resp;                              // last bus response
  logic [31:0] rdat;                              // last read word
  int          k;                                 // selected calendar pulse line

  // one good and one out-of-range word per watched register
  localparam logic [7:0]  V_OFF [4] = '{rtiv_pkg::OFF_TIME_DAY, rtiv_pkg::OFF_CALENDAR,
                                        rtiv_pkg::OFF_TIME_ALARM, rtiv_pkg::OFF_CAL_ALARM};
  localparam logic [31:0] V_GOOD [4] = '{32'h0012_3456, 32'h1565_2420, 32'h0000_00B0,
                                         32'h0085_0000};
  localparam logic [31:0] V_BAD [4] = '{32'h0012_3460, 32'h1573_2420, 32'h0000_00E0,
                                        32'h0093_0000};

  rtiv_regs dut_u (
    .CLK(CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .UPD_EVT(UPD_EVT), .ALARM_EVT(ALARM_EVT),
    .SEC_EVT(SEC_EVT), .TIME_EVTS(TIME_EVTS), .CAL_EVTS(CAL_EVTS), .IRQ(IRQ)
  );

  // 20 ns clock period
  always #10 CLK = ~CLK;

  // watchdog: the sequence needs under a thousand cycles, so this only cuts a hang
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // counts, verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // axi4-lite write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge CLK);
    S_AXI_AWADDR  <= a;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA   <= d;
    S_AXI_WSTRB   <= s;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_ok = 1'b1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_ok = 1'b1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    while (S_AXI_BVALID !== 1'b1) @(posedge CLK);
    resp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask

  // axi4-lite read: rready held until the data is seen
  task automatic axi_rd(input logic [7:0] a);
    @(posedge CLK);
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    do @(posedge CLK); while (!(S_AXI_ARVALID && S_AXI_ARREADY));
    S_AXI_ARVALID <= 1'b0;
    while (S_AXI_RVALID !== 1'b1) @(posedge CLK);
    rdat = S_AXI_RDATA;
    resp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask

  // read a register and compare with the expected word
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    axi_rd(a);
    `CHK(nm, ex, rdat)
  endtask

  // one-cycle event pulses; bit order of uas is update, alarm, second
  task automatic pulse(input logic [2:0] uas, input logic [3:0] t, input logic [2:0] c);
    @(posedge CLK);
    UPD_EVT   <= uas[0];
    ALARM_EVT <= uas[1];
    SEC_EVT   <= uas[2];
    TIME_EVTS <= t;
    CAL_EVTS  <= c;
    @(posedge CLK);
    UPD_EVT   <= 1'b0;
    ALARM_EVT <= 1'b0;
    SEC_EVT   <= 1'b0;
    TIME_EVTS <= 4'h0;
    CAL_EVTS  <= 3'h0;
    repeat (2) @(posedge CLK);
  endtask

  initial begin
    CLK = 1'b0;
    RST <= 1'b1;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} <= '0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} <= '0;
    {UPD_EVT, ALARM_EVT, SEC_EVT, TIME_EVTS, CAL_EVTS} <= '0;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    // mask: set-only enable, clear-only disable, read-only view
    rd_chk(rtiv_pkg::OFF_IRQ_MASK, 32'h0, "mask reset");
    `CHK("irq reset", 1'b0, IRQ)
    axi_wr(rtiv_pkg::OFF_IRQ_ON, 32'h05, 4'hF);
    `CHK("write resp", rtiv_pkg::RESP_OKAY, resp)
    axi_wr(rtiv_pkg::OFF_IRQ_ON, 32'h0A, 4'hF);
    rd_chk(rtiv_pkg::OFF_IRQ_MASK, 32'h0F, "mask set");
    axi_wr(rtiv_pkg::OFF_IRQ_OFF, 32'h01, 4'hF);
    axi_wr(rtiv_pkg::OFF_IRQ_OFF, 32'h00, 4'hF);
    rd_chk(rtiv_pkg::OFF_IRQ_MASK, 32'h0E, "mask cleared");
    axi_wr(rtiv_pkg::OFF_IRQ_MASK, 32'h1F, 4'hF);
    axi_wr(rtiv_pkg::OFF_IRQ_ON, 32'h10, 4'hE);
    rd_chk(rtiv_pkg::OFF_IRQ_MASK, 32'h0E, "mask untouched");
    rd_chk(rtiv_pkg::OFF_IRQ_ON, 32'h0, "enable reads zero");
    axi_rd(8'h40);
    `CHK("unmapped resp", rtiv_pkg::RESP_SLVERR, resp)
    `CHK("unmapped data", 32'h0, rdat)
    $display("test mask_access done");
    // each source on its own bit: mask, sticky flag, interrupt, clear
    for (int i = 0; i < 5; i++) begin
      axi_wr(rtiv_pkg::OFF_IRQ_OFF, 32'h1F, 4'hF);
      axi_wr(rtiv_pkg::OFF_IRQ_ON, 32'h1 << i, 4'hF);
      rd_chk(rtiv_pkg::OFF_IRQ_MASK, 32'h1 << i, "mask bit");
      pulse(3'((i < 3) ? (1 << i) : 0), 4'(i == 3), 3'(i == 4));
      `CHK("irq source", 1'b1, IRQ)
      rd_chk(rtiv_pkg::OFF_STATUS, 32'h1 << i, "status bit");
      axi_wr(rtiv_pkg::OFF_STAT_CLR, 32'h1 << i, 4'hF);
      rd_chk(rtiv_pkg::OFF_STATUS, 32'h0, "status cleared");
      repeat (3) @(posedge CLK);
      `CHK("irq released", 1'b0, IRQ)
    end
    $display("test source_bits done");
    // partial clears leave other flags; masked flags raise no interrupt
    pulse(3'h7, 4'h1, 3'h1);
    axi_wr(rtiv_pkg::OFF_STAT_CLR, 32'h00, 4'hF);
    rd_chk(rtiv_pkg::OFF_STATUS, 32'h1F, "clear zero");
    axi_wr(rtiv_pkg::OFF_STAT_CLR, 32'h0A, 4'hF);
    rd_chk(rtiv_pkg::OFF_STATUS, 32'h15, "clear some");
    axi_wr(rtiv_pkg::OFF_IRQ_OFF, 32'h1F, 4'hF);
    repeat (3) @(posedge CLK);
    `CHK("irq masked", 1'b0, IRQ)
    axi_wr(rtiv_pkg::OFF_STAT_CLR, 32'h1F, 4'hF);
    $display("test partial_clear done");
    // time event flag follows the selected event only
    axi_wr(rtiv_pkg::OFF_IRQ_ON, 32'h08, 4'hF);
    for (int s = 0; s < 4; s++) begin
      axi_wr(rtiv_pkg::OFF_CTRL, 32'(s) << rtiv_pkg::CTRL_TSEL_LSB, 4'hF);
      pulse(3'h0, 4'hF & ~(4'h1 << s), 3'h0);
      rd_chk(rtiv_pkg::OFF_STATUS, 32'h0, "time other");
      pulse(3'h0, 4'h1 << s, 3'h0);
      rd_chk(rtiv_pkg::OFF_STATUS, 32'h08, "time selected");
      `CHK("irq time", 1'b1, IRQ)
      axi_wr(rtiv_pkg::OFF_STAT_CLR, 32'h08, 4'hF);
    end
    // calendar event flag follows the selected event; 2 and 3 both pick year
    axi_wr(rtiv_pkg::OFF_IRQ_ON, 32'h10, 4'hF);
    for (int s = 0; s < 4; s++) begin
      k = (s > 2) ? 2 : s;
      axi_wr(rtiv_pkg::OFF_CTRL, 32'(s) << rtiv_pkg::CTRL_CSEL_LSB, 4'hF);
      pulse(3'h0, 4'h0, 3'h7 & ~(3'h1 << k));
      rd_chk(rtiv_pkg::OFF_STATUS, 32'h0, "cal other");
      pulse(3'h0, 4'h0, 3'h1 << k);
      rd_chk(rtiv_pkg::OFF_STATUS, 32'h10, "cal selected");
      axi_wr(rtiv_pkg::OFF_STAT_CLR, 32'h10, 4'hF);
    end
    $display("test event_select done");
    // validity: each watched register judged on its own write
    for (int i = 0; i < 4; i++) axi_wr(V_OFF[i], V_GOOD[i], 4'hF);
    rd_chk(rtiv_pkg::OFF_VALIDITY, 32'h0, "all valid");
    for (int i = 0; i < 4; i++) begin
      axi_wr(V_OFF[i], V_BAD[i], 4'hF);
      rd_chk(rtiv_pkg::OFF_VALIDITY, 32'h1 << i, "bad entry");
      axi_wr(rtiv_pkg::OFF_VALIDITY, 32'h0, 4'hF);
      rd_chk(rtiv_pkg::OFF_VALIDITY, 32'h1 << i, "validity ro");
      axi_wr(V_OFF[i], V_GOOD[i], 4'hF);
      rd_chk(rtiv_pkg::OFF_VALIDITY, 32'h0, "entry fixed");
    end
    $display("test validity done");
    // reset in mid-run: flags, mask and interrupt return to their reset values
    pulse(3'h7, 4'h1, 3'h7);
    `CHK("irq before reset", 1'b1, IRQ)
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rd_chk(rtiv_pkg::OFF_STATUS, 32'h0, "status after reset");
    rd_chk(rtiv_pkg::OFF_IRQ_MASK, 32'(rtiv_pkg::MASK_RST), "mask after reset");
    `CHK("irq after reset", 1'b0, IRQ)
    $display("test mid_reset done");
    close_out();
  end
endmodule // tb_top
